// ==== phc_core.sv ====
// packet handler configuration core: serial register port, packet
// handling controls, address filter, crc policy and clock output
// assumes serial pins are asynchronous; datapath strobes share clk_sys
`timescale 1ns/10ps

// Functional notes
// - reference clock pin driven only while clock output enable is set
// - divider field 0 gives crystal clock, else crystal over twice field
// - manchester encode and decode only while its enable bit is set
// - fixed format uses the length field as exact payload length
// - variable format: length field caps receive, ignored on transmit
// - node address register resets to zero, used by the filter
// - preamble field selects one to four transmitted bytes
// - whitening and dewhitening only while its enable bit is set
// - crc appended and checked while crc enable set, default on
// - filter accepts all, node, node or zero, node zero or ones
// - read-only status bit shows last crc outcome, one is pass
// - failed crc clears the fifo unless the keep bit is set
// - standby fifo direction bit: zero write, one read
// - two banks of three eight-bit divider registers at six to eleven
// - one serial write switches the active divider bank
// - receive channel may change with the receiver kept powered
module phc_core
  import phc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic ref_clk_out,
  output logic ref_clk_oe,
  output logic manchester_en,
  output logic whitening_en,
  output logic crc_en,
  output logic variable_length,
  output logic [6:0] tx_payload_len,
  output logic tx_len_from_packet,
  output logic [2:0] preamble_bytes,
  input wire logic rx_addr_valid,
  input wire logic [7:0] rx_addr,
  output logic rx_addr_accept,
  output logic rx_addr_reject,
  input wire logic rx_len_valid,
  input wire logic [6:0] rx_len,
  output logic rx_len_reject,
  input wire logic rx_crc_done,
  input wire logic rx_crc_ok,
  output logic fifo_clear,
  input wire logic standby_mode,
  output logic fifo_stby_write_en,
  output logic fifo_stby_read_en,
  output logic [7:0] synth_r_div,
  output logic [7:0] synth_p_div,
  output logic [7:0] synth_s_div,
  input wire logic rx_active,
  output logic rx_hop_req,
  input wire logic synth_lock,
  output logic synth_lock_irq
);

  // pin synchronisers; the first stage feeds only the second
  logic [1:0] cs_n_sync;
  logic [2:0] sck_sync;
  logic [1:0] mosi_sync;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cs_n_sync <= 2'b11;
      sck_sync <= 3'b000;
      mosi_sync <= 2'b00;
    end else begin
      cs_n_sync <= {cs_n_sync[0], spi_cs_n};
      sck_sync <= {sck_sync[1:0], spi_sck};
      mosi_sync <= {mosi_sync[0], spi_mosi};
    end
  end

  wire cs_act = ~cs_n_sync[1];
  wire sck_rise = sck_sync[1] & ~sck_sync[2];
  wire mosi_bit = mosi_sync[1];

  // serial port state
  phc_spi_state_t state_reg;
  phc_spi_state_t state_next;
  logic [2:0] bit_reg;
  logic [6:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic read_reg;
  logic [6:0] addr_reg;
  logic [6:0] addr_next;
  logic wr_en_reg;
  logic [6:0] wr_addr_reg;
  logic [7:0] wr_data_reg;

  wire byte_done = sck_rise && (bit_reg == PHC_LAST_BIT);
  wire [7:0] rx_byte = {shift_reg, mosi_bit};
  wire cmd_done = byte_done && (state_reg == PHC_SPI_CMD);
  wire data_done = byte_done && (state_reg == PHC_SPI_DATA);
  wire [6:0] rd_addr = cmd_done ? rx_byte[6:0] : addr_reg + 7'h01;

  // configuration registers
  logic [7:0] bank_reg;
  logic [7:0] div_reg [0:PHC_DIV_REGS-1];
  logic [7:0] clkout_reg;
  logic [7:0] coding_reg;
  logic [7:0] node_reg;
  logic [7:0] format_reg;
  logic [7:0] fifo_reg;
  logic crc_stat_reg;
  logic [7:0] rd_data;

  // index within the divider block, offset truncated to three bits
  function automatic logic [2:0] div_index(input logic [6:0] a);
    logic [6:0] d;
    d = a - PHC_ADDR_DIV_FIRST;
    return d[2:0];
  endfunction

  function automatic logic in_div(input logic [6:0] a);
    return (a >= PHC_ADDR_DIV_FIRST) && (a <= PHC_ADDR_DIV_LAST);
  endfunction

  // read decode; unmapped addresses answer zero
  wire [7:0] format_rd = {format_reg[7:1], crc_stat_reg};
  assign rd_data =
    (rd_addr == PHC_ADDR_BANK_SEL) ? bank_reg :
    in_div(rd_addr) ? div_reg[div_index(rd_addr)] :
    (rd_addr == PHC_ADDR_CLKOUT) ? clkout_reg :
    (rd_addr == PHC_ADDR_CODING) ? coding_reg :
    (rd_addr == PHC_ADDR_NODE) ? node_reg :
    (rd_addr == PHC_ADDR_FORMAT) ? format_rd :
    (rd_addr == PHC_ADDR_FIFO) ? fifo_reg : PHC_RD_UNMAPPED;

  // command byte: bit 7 read, 6..0 address; data bytes auto-increment
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    tx_next = tx_reg;
    if (!cs_act) begin
      state_next = PHC_SPI_IDLE;
    end else begin
      case (state_reg)
        PHC_SPI_IDLE: begin
          state_next = PHC_SPI_CMD;
        end
        PHC_SPI_CMD: begin
          if (cmd_done) begin
            state_next = PHC_SPI_DATA;
            addr_next = rx_byte[6:0];
            tx_next = rd_data;
          end
        end
        PHC_SPI_DATA: begin
          if (data_done) begin
            addr_next = addr_reg + 7'h01;
            tx_next = rd_data;
          end else if (sck_rise) begin
            tx_next = {tx_reg[6:0], 1'b0};
          end
        end
        default: begin
          state_next = PHC_SPI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg <= PHC_SPI_IDLE;
      addr_reg <= 7'h00;
      tx_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      tx_reg <= tx_next;
    end
  end

  // bit counter and shifter restart with every chip select
  always_ff @(posedge clk_sys) begin
    if (!rstn || !cs_act) begin
      bit_reg <= 3'h0;
      shift_reg <= 7'h00;
    end else if (sck_rise) begin
      bit_reg <= bit_reg + 3'h1;
      shift_reg <= rx_byte[6:0];
    end
  end

  // direction latched from the command byte
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      read_reg <= 1'b0;
    end else if (cmd_done) begin
      read_reg <= rx_byte[7];
    end
  end

  // write strobe one cycle after the last data bit
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 7'h00;
      wr_data_reg <= 8'h00;
    end else begin
      wr_en_reg <= data_done && !read_reg;
      wr_addr_reg <= addr_reg;
      wr_data_reg <= rx_byte;
    end
  end

  // miso drives only during the data phase of a read
  assign spi_miso = tx_reg[7];
  assign spi_miso_oe = cs_act && read_reg && (state_reg == PHC_SPI_DATA);

  wire wr_bank = wr_en_reg && (wr_addr_reg == PHC_ADDR_BANK_SEL);
  wire wr_div = wr_en_reg && in_div(wr_addr_reg);
  wire wr_clk = wr_en_reg && (wr_addr_reg == PHC_ADDR_CLKOUT);
  wire wr_cod = wr_en_reg && (wr_addr_reg == PHC_ADDR_CODING);
  wire wr_node = wr_en_reg && (wr_addr_reg == PHC_ADDR_NODE);
  wire wr_fmt = wr_en_reg && (wr_addr_reg == PHC_ADDR_FORMAT);
  wire wr_fifo = wr_en_reg && (wr_addr_reg == PHC_ADDR_FIFO);

  // register file writes
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      bank_reg <= PHC_RST_BANK_SEL;
      clkout_reg <= PHC_RST_CLKOUT;
      coding_reg <= PHC_RST_CODING;
      node_reg <= PHC_RST_NODE;
      format_reg <= PHC_RST_FORMAT;
      fifo_reg <= PHC_RST_FIFO;
    end else begin
      if (wr_bank) bank_reg <= wr_data_reg;
      if (wr_clk) clkout_reg <= wr_data_reg;
      if (wr_cod) coding_reg <= wr_data_reg;
      if (wr_node) node_reg <= wr_data_reg;
      if (wr_fmt) format_reg <= wr_data_reg; // status bit is shadowed
      if (wr_fifo) fifo_reg <= wr_data_reg;
    end
  end

  // synthesizer divider banks, two sets of three
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < PHC_DIV_REGS; i++) begin
        div_reg[i] <= PHC_RST_DIV;
      end
    end else if (wr_div) begin
      div_reg[div_index(wr_addr_reg)] <= wr_data_reg;
    end
  end

  // crc result only ever comes from the checker, never from a write
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      crc_stat_reg <= 1'b0;
    end else if (rx_crc_done && crc_en) begin
      crc_stat_reg <= rx_crc_ok;
    end
  end

  // bank select switches all three dividers at once
  wire bank_hi = bank_reg[PHC_BIT_BANK];
  wire [2:0] bank_base = bank_hi ? 3'(PHC_DIV_PER_BANK) : 3'h0;
  logic bank_d_reg;
  logic [7:0] r_div_reg;
  logic [7:0] p_div_reg;
  logic [7:0] s_div_reg;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r_div_reg <= PHC_RST_DIV;
      p_div_reg <= PHC_RST_DIV;
      s_div_reg <= PHC_RST_DIV;
      bank_d_reg <= 1'b0;
    end else begin
      r_div_reg <= div_reg[bank_base];
      p_div_reg <= div_reg[bank_base + 3'h1];
      s_div_reg <= div_reg[bank_base + 3'h2];
      bank_d_reg <= bank_hi;
    end
  end

  assign synth_r_div = r_div_reg;
  assign synth_p_div = p_div_reg;
  assign synth_s_div = s_div_reg;

  // a bank change with the receiver up retunes without a power cycle;
  // faster than a full restart at the cost of receiver current
  logic hop_reg;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hop_reg <= 1'b0;
    end else begin
      hop_reg <= rx_active && (bank_hi != bank_d_reg);
    end
  end
  assign rx_hop_req = hop_reg;

  // lock indicator forwarded for the host's interrupt pin
  logic lock_reg;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lock_reg <= 1'b0;
    end else begin
      lock_reg <= synth_lock;
    end
  end
  assign synth_lock_irq = lock_reg;

  // packet handling controls straight from the registers
  assign manchester_en = coding_reg[PHC_BIT_MANCH];
  assign whitening_en = format_reg[PHC_BIT_WHITEN];
  assign crc_en = format_reg[PHC_BIT_CRC_ON];
  assign variable_length = format_reg[PHC_BIT_VARLEN];
  assign tx_payload_len = coding_reg[PHC_LEN_HI:0];
  assign tx_len_from_packet = variable_length;
  assign preamble_bytes =
    {1'b0, format_reg[PHC_PRE_HI:PHC_PRE_LO]} + 3'h1;
  assign fifo_stby_write_en =
    standby_mode && !fifo_reg[PHC_BIT_STBY_READ];
  assign fifo_stby_read_en =
    standby_mode && fifo_reg[PHC_BIT_STBY_READ];

  // address filter decision
  wire [1:0] filt = format_reg[PHC_FILT_HI:PHC_FILT_LO];
  wire hit_node = (rx_addr == node_reg);
  wire hit_zero = (rx_addr == PHC_BCAST_ZERO);
  wire hit_ones = (rx_addr == PHC_BCAST_ONES);
  wire addr_ok =
    (filt == PHC_FILT_OFF) ? 1'b1 :
    (filt == PHC_FILT_NODE) ? hit_node :
    (filt == PHC_FILT_NODE_BC0) ? (hit_node || hit_zero) :
    (hit_node || hit_zero || hit_ones);

  // length check: fixed mode must match, variable mode is a ceiling
  wire len_bad = variable_length ? (rx_len > tx_payload_len) :
                 (rx_len != tx_payload_len);

  // a failed crc flushes the fifo unless the keep bit is set
  wire crc_flush = rx_crc_done && crc_en && !rx_crc_ok &&
                   !fifo_reg[PHC_BIT_KEEP_FIFO];

  logic acc_reg;
  logic rej_reg;
  logic len_rej_reg;
  logic clr_reg;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      acc_reg <= 1'b0;
      rej_reg <= 1'b0;
      len_rej_reg <= 1'b0;
      clr_reg <= 1'b0;
    end else begin
      acc_reg <= rx_addr_valid && addr_ok;
      rej_reg <= rx_addr_valid && !addr_ok;
      len_rej_reg <= rx_len_valid && len_bad;
      clr_reg <= crc_flush;
    end
  end

  assign rx_addr_accept = acc_reg;
  assign rx_addr_reject = rej_reg;
  assign rx_len_reject = len_rej_reg;
  assign fifo_clear = clr_reg;

  // reference clock output
  phc_clkout u_clkout (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clk_en(clkout_reg[PHC_BIT_CLKOUT_ON]),
    .clk_div(clkout_reg[PHC_CLKDIV_HI:PHC_CLKDIV_LO]),
    .clk_out(ref_clk_out),
    .clk_oe(ref_clk_oe)
  );

endmodule

// ==== phc_pkg.sv ====
// register map, field layout and reset values of the packet handler
// configuration block; shared by the core and the clock output divider
package phc_pkg;

  // register addresses on the serial port
  localparam logic [6:0] PHC_ADDR_BANK_SEL = 7'h00;
  localparam logic [6:0] PHC_ADDR_DIV_FIRST = 7'h06;
  localparam logic [6:0] PHC_ADDR_DIV_LAST = 7'h0B;
  localparam logic [6:0] PHC_ADDR_CLKOUT = 7'h1B;
  localparam logic [6:0] PHC_ADDR_CODING = 7'h1C;
  localparam logic [6:0] PHC_ADDR_NODE = 7'h1D;
  localparam logic [6:0] PHC_ADDR_FORMAT = 7'h1E;
  localparam logic [6:0] PHC_ADDR_FIFO = 7'h1F;

  // reset values
  localparam logic [7:0] PHC_RST_BANK_SEL = 8'h00;
  localparam logic [7:0] PHC_RST_DIV = 8'h00;
  localparam logic [7:0] PHC_RST_CLKOUT = 8'hBC;
  localparam logic [7:0] PHC_RST_CODING = 8'h00;
  localparam logic [7:0] PHC_RST_NODE = 8'h00;
  localparam logic [7:0] PHC_RST_FORMAT = 8'h48;
  localparam logic [7:0] PHC_RST_FIFO = 8'h00;
  localparam logic [7:0] PHC_RD_UNMAPPED = 8'h00;

  // field positions
  localparam int PHC_BIT_CLKOUT_ON = 7;
  localparam int PHC_CLKDIV_HI = 6;
  localparam int PHC_CLKDIV_LO = 2;
  localparam int PHC_BIT_MANCH = 7;
  localparam int PHC_LEN_HI = 6;
  localparam int PHC_BIT_VARLEN = 7;
  localparam int PHC_PRE_HI = 6;
  localparam int PHC_PRE_LO = 5;
  localparam int PHC_BIT_WHITEN = 4;
  localparam int PHC_BIT_CRC_ON = 3;
  localparam int PHC_FILT_HI = 2;
  localparam int PHC_FILT_LO = 1;
  localparam int PHC_BIT_CRC_STAT = 0;
  localparam int PHC_BIT_KEEP_FIFO = 7;
  localparam int PHC_BIT_STBY_READ = 6;
  localparam int PHC_BIT_BANK = 0;

  // address filter modes
  localparam logic [1:0] PHC_FILT_OFF = 2'h0;
  localparam logic [1:0] PHC_FILT_NODE = 2'h1;
  localparam logic [1:0] PHC_FILT_NODE_BC0 = 2'h2;

  // broadcast addresses
  localparam logic [7:0] PHC_BCAST_ZERO = 8'h00;
  localparam logic [7:0] PHC_BCAST_ONES = 8'hFF;

  // serial framing and divider bank sizes
  localparam logic [2:0] PHC_LAST_BIT = 3'h7;
  localparam int PHC_DIV_REGS = 6;
  localparam int PHC_DIV_PER_BANK = 3;

  // serial port state machine, one-hot
  typedef enum logic [2:0] {
    PHC_SPI_IDLE = 3'b001,
    PHC_SPI_CMD = 3'b010,
    PHC_SPI_DATA = 3'b100
  } phc_spi_state_t;

endpackage

// ==== phc_clkout.sv ====
// reference clock output: divides clk_sys by twice the divider field; field zero passes clk_sys
// assumes clk_sys is the crystal reference clock and rstn is synchronous
`timescale 1ns/10ps
module phc_clkout
  import phc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [4:0] clk_div,
  output logic clk_out,
  output logic clk_oe
);

  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic tog_reg;
  logic tog_next;
  logic en_reg;
  wire div_zero = (clk_div == 5'h00);
  wire cnt_wrap = (cnt_reg >= clk_div - 5'h01);

  // half-period counter; wrap also catches a divider lowered mid-count
  assign cnt_next = (cnt_wrap || div_zero) ? 5'h00 : cnt_reg + 5'h01;
  assign tog_next = (!en_reg || div_zero) ? 1'b0 :
                    (cnt_wrap ? ~tog_reg : tog_reg);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_reg <= 5'h00;
      tog_reg <= 1'b0;
      en_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tog_reg <= tog_next;
      en_reg <= clk_en;
    end
  end

  // undivided case gates the reference itself; the enable is registered
  // so the gate only changes while clk_sys is high, limiting glitches
  assign clk_out = div_zero ? (clk_sys & en_reg) : tog_reg;
  assign clk_oe = en_reg;

endmodule

// ==== phc_core_assertions.sv ====
// port checker for the packet handler configuration core
// assumes one clock domain, rstn synchronous active low
`timescale 1ns/10ps
module phc_core_assertions (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic rx_addr_valid,
  input wire logic rx_addr_accept,
  input wire logic rx_addr_reject,
  input wire logic rx_len_valid,
  input wire logic rx_len_reject,
  input wire logic rx_crc_done,
  input wire logic rx_crc_ok,
  input wire logic crc_en,
  input wire logic fifo_clear,
  input wire logic tx_len_from_packet,
  input wire logic variable_length,
  input wire logic [2:0] preamble_bytes,
  input wire logic standby_mode,
  input wire logic fifo_stby_write_en,
  input wire logic fifo_stby_read_en,
  input wire logic rx_active,
  input wire logic rx_hop_req,
  input wire logic synth_lock,
  input wire logic synth_lock_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // each filter request gets exactly one verdict, next cycle
  addr_one_verdict_a: assert property (rx_addr_valid |=>
    (rx_addr_accept ^ rx_addr_reject)) else $error("addr verdict missing");
  addr_no_spurious_a: assert property ((rx_addr_accept ||
    rx_addr_reject) |-> $past(rx_addr_valid)) else $error("stray verdict");
  len_reject_cause_a: assert property (rx_len_reject |->
    $past(rx_len_valid)) else $error("stray length reject");
  // clearing only on a failed check with the check enabled
  clear_cause_a: assert property (fifo_clear |->
    $past(rx_crc_done && !rx_crc_ok && crc_en)) else $error("stray clear");
  pass_keeps_fifo_a: assert property (rx_crc_done && rx_crc_ok |=>
    !fifo_clear) else $error("clear on pass");
  crc_off_keeps_a: assert property (rx_crc_done && !crc_en |=>
    !fifo_clear) else $error("clear with crc off");
  tx_len_source_a: assert property (tx_len_from_packet ==
    variable_length) else $error("tx length source wrong");
  preamble_range_a: assert property (preamble_bytes inside
    {[3'h1:3'h4]}) else $error("preamble size out of range");
  stby_dir_excl_a: assert property ((fifo_stby_write_en ||
    fifo_stby_read_en) |-> standby_mode &&
    !(fifo_stby_write_en && fifo_stby_read_en)) else $error("stby dir");
  hop_needs_rx_a: assert property (rx_hop_req |->
    $past(rx_active)) else $error("hop without receiver");
  lock_irq_follow_a: assert property ($rose(synth_lock) |=>
    synth_lock_irq) else $error("lock irq late");

  cover property (fifo_clear);
  cover property (rx_hop_req);
  cover property (rx_addr_valid ##1 rx_addr_reject);
endmodule

bind phc_core phc_core_assertions u_chk (.clk_sys, .rstn, .rx_addr_valid,
  .rx_addr_accept, .rx_addr_reject, .rx_len_valid, .rx_len_reject,
  .rx_crc_done, .rx_crc_ok, .crc_en, .fifo_clear, .tx_len_from_packet,
  .variable_length, .preamble_bytes, .standby_mode, .fifo_stby_write_en,
  .fifo_stby_read_en, .rx_active, .rx_hop_req, .synth_lock,
  .synth_lock_irq);

// ==== phc_host_model.sv ====
// host model: serial master for the core's register port
// assumes clk_sys from the bench; mode 0, msb first, 12 clk per bit
`timescale 1ns/10ps
module phc_host_model (
  input wire logic clk_sys,
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
  end

  // one byte; slow half periods keep the core's synchronisers happy
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi <= tx[i];
      repeat (6) @(posedge clk_sys);
      spi_sck <= 1'b1;
      rx[i] = spi_miso;
      repeat (6) @(posedge clk_sys);
      spi_sck <= 1'b0;
    end
  endtask

  // single framed access, one command byte and one data byte
  task automatic access(input logic rd, input logic [6:0] a,
                        input logic [7:0] wd, output logic [7:0] rdat);
    logic [7:0] cmd_echo;
    @(posedge clk_sys);
    spi_cs_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    shift({rd, a}, cmd_echo);
    shift(wd, rdat);
    repeat (8) @(posedge clk_sys);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi; // released line must not look held
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

// ==== phc_core_bench.sv ====
// self-checking bench for phc_core, driven through the host model
// assumes the bind in the checker file attaches the assertions
`timescale 1ns/10ps
module phc_core_bench
  import phc_pkg::*;
;
  localparam logic [6:0] RA [0:6] = '{7'h1B, 7'h1C, 7'h1D, 7'h1E, 7'h1F,
    7'h00, 7'h06};
  localparam logic [7:0] RV [0:6] = '{8'hBC, 8'h00, 8'h00, 8'h48, 8'h00,
    8'h00, 8'h00};
  localparam logic [3:0] FX [0:3] = '{4'hF, 4'h8, 4'hC, 4'hE};
  localparam logic [7:0] FA [0:3] = '{8'h5A, 8'h00, 8'hFF, 8'h33};
  logic clk_sys, rstn, spi_cs_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
  logic ref_clk_out, ref_clk_oe, manchester_en, whitening_en, crc_en;
  logic variable_length, tx_len_from_packet, rx_addr_valid, rx_addr_accept;
  logic rx_addr_reject, rx_len_valid, rx_len_reject, rx_crc_done, rx_crc_ok;
  logic fifo_clear, standby_mode, fifo_stby_write_en, fifo_stby_read_en;
  logic rx_active, rx_hop_req, synth_lock, synth_lock_irq;
  logic [6:0] tx_payload_len, rx_len;
  logic [2:0] preamble_bytes;
  logic [7:0] rx_addr, synth_r_div, synth_p_div, synth_s_div;
  int errors = 0, n_tests = 0, hop_cnt = 0;

  phc_host_model u_host (.clk_sys, .spi_cs_n, .spi_sck, .spi_mosi,
    .spi_miso);
  phc_core u_dut (.clk_sys, .rstn, .spi_cs_n, .spi_sck, .spi_mosi,
    .spi_miso, .spi_miso_oe, .ref_clk_out, .ref_clk_oe, .manchester_en,
    .whitening_en, .crc_en, .variable_length, .tx_payload_len,
    .tx_len_from_packet, .preamble_bytes, .rx_addr_valid, .rx_addr,
    .rx_addr_accept, .rx_addr_reject, .rx_len_valid, .rx_len,
    .rx_len_reject, .rx_crc_done, .rx_crc_ok, .fifo_clear, .standby_mode,
    .fifo_stby_write_en, .fifo_stby_read_en, .synth_r_div, .synth_p_div,
    .synth_s_div, .rx_active, .rx_hop_req, .synth_lock, .synth_lock_irq);

  always #2 clk_sys = ~clk_sys;
  // hop requests counted as they pass
  always @(posedge clk_sys) if (rx_hop_req === 1'b1) hop_cnt <= hop_cnt + 1;

  task automatic check(input string what, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    u_host.access(1'b0, a, d, v);
  endtask

  task automatic rd_chk(input string what, input logic [6:0] a,
                        input logic [7:0] exp);
    logic [7:0] v;
    u_host.access(1'b1, a, 8'h00, v);
    check(what, v, exp);
  endtask

  // one-cycle strobes; the answer pulse is looked at the cycle after
  task automatic addr_req(input logic [7:0] a, input logic ok);
    rx_addr_valid <= 1'b1;
    rx_addr <= a;
    @(posedge clk_sys);
    rx_addr_valid <= 1'b0;
    #1;
    check("accept", rx_addr_accept, ok);
    check("reject", rx_addr_reject, !ok);
    @(posedge clk_sys);
  endtask

  task automatic len_req(input logic [6:0] l, input logic rej);
    rx_len_valid <= 1'b1;
    rx_len <= l;
    @(posedge clk_sys);
    rx_len_valid <= 1'b0;
    #1;
    check("len reject", rx_len_reject, rej);
    @(posedge clk_sys);
  endtask

  task automatic crc_req(input logic ok, input logic clr);
    rx_crc_done <= 1'b1;
    rx_crc_ok <= ok;
    @(posedge clk_sys);
    rx_crc_done <= 1'b0;
    #1;
    check("fifo clear", fifo_clear, clr);
    @(posedge clk_sys);
  endtask

  // counts output rises over 120 cycles, four periods at the reset divider
  task automatic count_rises(input string what, input logic [7:0] exp);
    logic last;
    logic [7:0] n;
    n = 8'h00;
    #1;
    last = ref_clk_out;
    repeat (120) begin
      @(posedge clk_sys);
      #1;
      if (ref_clk_out === 1'b1 && last === 1'b0) n++;
      last = ref_clk_out;
    end
    check(what, n, exp);
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge clk_sys);
    errors++;
    print_verdict();
  end

  initial begin
    {clk_sys, rstn, rx_addr_valid, rx_len_valid, rx_crc_done} = 5'h00;
    {rx_crc_ok, standby_mode, rx_active, synth_lock} = 4'h0;
    rx_addr = 8'h00;
    rx_len = 7'h00;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    foreach (RA[i]) rd_chk("reset value", RA[i], RV[i]);
    check("levels", {ref_clk_oe, crc_en, manchester_en, whitening_en,
      variable_length, preamble_bytes}, 8'hC3);
    check("miso oe idle", spi_miso_oe, 1'b0);
    count_rises("clk div 15", 8'h04);
    wr(PHC_ADDR_CLKOUT, 8'h88);
    count_rises("clk div 2", 8'h1E);
    // undivided output follows the reference: high, then low mid-cycle
    wr(PHC_ADDR_CLKOUT, 8'h80);
    #1;
    check("div0 high", ref_clk_out, 1'b1);
    #2;
    check("div0 low", ref_clk_out, 1'b0);
    wr(PHC_ADDR_CLKOUT, 8'h3C);
    check("clk oe off", ref_clk_oe, 1'b0);
    count_rises("clk off", 8'h00);
    // fixed length then variable length handling
    wr(PHC_ADDR_CODING, 8'h94);
    check("manch len", {manchester_en, tx_payload_len}, 8'h94);
    len_req(7'h14, 1'b0);
    len_req(7'h15, 1'b1);
    len_req(7'h13, 1'b1);
    wr(PHC_ADDR_FORMAT, 8'h98);
    check("var fmt", {variable_length, tx_len_from_packet, whitening_en,
      preamble_bytes}, 8'h39);
    len_req(7'h15, 1'b1);
    len_req(7'h13, 1'b0);
    for (int p = 0; p < 4; p++) begin
      wr(PHC_ADDR_FORMAT, {1'b0, 2'(p), 5'h08});
      check("preamble", {5'h00, preamble_bytes}, 8'(p + 1));
    end
    // crc status, its write protection and the clear policy
    wr(PHC_ADDR_FORMAT, 8'h09);
    rd_chk("status ro", PHC_ADDR_FORMAT, 8'h08);
    crc_req(1'b1, 1'b0);
    wr(PHC_ADDR_FORMAT, 8'h08);
    rd_chk("status pass", PHC_ADDR_FORMAT, 8'h09);
    crc_req(1'b0, 1'b1);
    rd_chk("status fail", PHC_ADDR_FORMAT, 8'h08);
    wr(PHC_ADDR_FIFO, 8'h80);
    crc_req(1'b0, 1'b0);
    wr(PHC_ADDR_FIFO, 8'h00);
    wr(PHC_ADDR_FORMAT, 8'h00);
    crc_req(1'b0, 1'b0);
    // every filter mode against node, zero, ones and a stranger
    wr(PHC_ADDR_NODE, 8'h5A);
    for (int m = 0; m < 4; m++) begin
      wr(PHC_ADDR_FORMAT, {5'h01, 2'(m), 1'b0});
      for (int a = 0; a < 4; a++) addr_req(FA[a], FX[m][3 - a]);
    end
    standby_mode <= 1'b1;
    @(posedge clk_sys);
    #1;
    check("stby write", {fifo_stby_write_en, fifo_stby_read_en}, 8'h02);
    wr(PHC_ADDR_FIFO, 8'h40);
    check("stby read", {fifo_stby_write_en, fifo_stby_read_en}, 8'h01);
    // divider banks and a receive hop by one bank write
    for (int i = 0; i < 6; i++) wr(7'(6 + i), 8'(17 * (i + 1)));
    check("bank0 r", synth_r_div, 8'h11);
    check("bank0 s", synth_s_div, 8'h33);
    rx_active <= 1'b1;
    wr(PHC_ADDR_BANK_SEL, 8'h01);
    check("hop", 8'(hop_cnt), 8'h01);
    check("bank1 p", synth_p_div, 8'h55);
    synth_lock <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check("lock irq", synth_lock_irq, 1'b1);
    print_verdict();
  end
endmodule
